// *** async_uart_receiver_and_tx_setup_test.sv ***
// testbench: register and receive path checks for the transceiver
`timescale 1ns/1ps
module async_uart_receiver_and_tx_setup_test;
	import uart_rx_pkg::*;
	logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, expv;
	logic ack, err, rx, rx_oe, tx_oe, irq;
	logic [7:0] b[4];
	logic [31:0] exp_q[$];
	int failures = 0, n_tests = 0;
	always #10 clk = ~clk;
	uart_rx_core dut (.CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .WB_ERR_O(err), .SERIAL_IN_PIN_I(rx), .SERIAL_IN_PIN_OE(rx_oe),
		.SERIAL_OUT_PIN_OE(tx_oe), .IRQ(irq));
	// divisor 1 gives 32 clocks a bit
	serial_peer #(.BIT_CLKS(32)) peer (.clk(clk), .line(rx));
	// ==========
	// bus tasks
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// read results meet their notes here, oldest first
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			expv = exp_q.pop_front();
			n_tests++;
			if (rdat !== expv) begin
				failures++;
				$display("unexpected at %0t: got %h, expected %h", $time, rdat, expv);
			end
		end
	end
	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		#400000;
		failures++;
		summarize();
	end
	initial begin
		void'($urandom(18828));
		foreach (b[i]) b[i] = 8'($urandom);
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		wr(ADDR_DIVISOR, 32'h1);
		wr(ADDR_CTRL, 32'h9);
		rd(ADDR_STATUS, 32'h0);
		wr(ADDR_CTRL, 32'hd);
		rd(ADDR_STATUS, 32'h1);
		wr(ADDR_CTRL, 32'h68d);
		rd(ADDR_STATUS, 32'h21);
		wr(ADDR_CTRL, 32'hd);
		$display("test setup done");
		peer.glitch();
		peer.send({1'b0, b[0]}, 8, 1'b1);
		rd(ADDR_STATUS, 32'h3);
		rd(ADDR_RXDATA, {24'h0, b[0]});
		rd(ADDR_STATUS, 32'h1);
		$display("test single done");
		peer.send({1'b0, b[1]}, 8, 1'b1);
		peer.send({1'b0, b[2]}, 8, 1'b0);
		peer.send({1'b0, b[3]}, 8, 1'b1);
		rd(ADDR_STATUS, 32'hb);
		rd(ADDR_RXDATA, {24'h0, b[1]});
		rd(ADDR_STATUS, 32'hb);
		rd(ADDR_RXDATA, {24'h0, b[2]});
		rd(ADDR_STATUS, 32'hd);
		peer.send({1'b0, b[3]}, 8, 1'b1);
		rd(ADDR_STATUS, 32'hd);
		wr(ADDR_CTRL, 32'h5);
		rd(ADDR_STATUS, 32'h5);
		$display("test overrun done");
		wr(ADDR_CTRL, 32'h72d);
		peer.send({1'b1, b[0]}, 9, 1'b1);
		rd(ADDR_STATUS, 32'h27);
		rd(ADDR_RXDATA, {24'h0, b[0]});
		rd(ADDR_STATUS, 32'h11);
		peer.send({1'b0, b[1]}, 9, 1'b0);
		rd(ADDR_STATUS, 32'h33);
		rd(ADDR_RXDATA, {24'h0, b[1]});
		rd(ADDR_STATUS, 32'h5);
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		$display("test nine bit done");
		wr(ADDR_CTRL, 32'hb);
		peer.send({1'b0, b[2]}, 8, 1'b1);
		rd(ADDR_STATUS, 32'h0);
		wr(ADDR_STATUS, 32'hff);
		rd(ADDR_STATUS, 32'h0);
		rd(4'h2, 32'h0);
		$display("test access done");
		summarize();
	end
endmodule

// *** rx_fifo.sv ***
// two-entry receive buffer holding nine data bits and a frame error flag per entry
`timescale 1ns/1ps
module rx_fifo #(
	parameter int WIDTH = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic clear,
	// write side
	input wire logic push,
	input wire logic [WIDTH-1:0] wdata,
	// read side
	input wire logic pop,
	output logic [WIDTH-1:0] rdata,
	output logic empty,
	output logic full
);
	logic [WIDTH-1:0] mem_reg [2];
	logic rd_reg;
	logic wr_reg;
	logic [1:0] cnt_reg;
	logic wr_ok;
	logic rd_ok;

	assign rdata = mem_reg[rd_reg];
	assign empty = (cnt_reg == 2'h0);
	assign full = (cnt_reg == 2'h2);
	assign rd_ok = pop && !empty;
	// a full buffer still takes a character in the cycle its oldest entry is read
	assign wr_ok = push && (!full || rd_ok);

	always_ff @(posedge clk) begin
		if (wr_ok) begin
			mem_reg[wr_reg] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			if (wr_ok) begin
				wr_reg <= ~wr_reg;
			end
			if (rd_ok) begin
				rd_reg <= ~rd_reg;
			end
			if (wr_ok && !rd_ok) begin
				cnt_reg <= cnt_reg + 2'h1;
			end else if (!wr_ok && rd_ok) begin
				cnt_reg <= cnt_reg - 2'h1;
			end
		end
	end
endmodule

// *** serial_peer.sv ***
// remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT_CLKS = 32
) (
	// clock and line
	input wire logic clk,
	output logic line
);
	// idle at mark level
	initial line = 1'b1;
	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge clk);
	endtask
	// ninth bit high marks an address byte
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		hold(1'b0, BIT_CLKS);
		for (int i = 0; i < n; i++) hold(d[i], BIT_CLKS);
		hold(stop, BIT_CLKS);
		hold(1'b1, BIT_CLKS);
	endtask
	// short low pulse, too short to be a start bit
	task automatic glitch;
		hold(1'b0, 3);
		hold(1'b1, BIT_CLKS);
	endtask
endmodule

// *** uart_rx_core.sv ***
// serial transceiver: transmit setup, full asynchronous receive path, wishbone slave
//
// What this block does
// (RULE_01) turning on transmit enable raises the buffer-empty flag at once
// (RULE_02) sender sets ninth bit to one to mark an address byte
// (RULE_03) software sets divisor, port, nine-bit, enable, interrupts, then loads data
// (RULE_04) tx interrupt requested when all enables and buffer-empty flag are set
// (RULE_05) recovery runs at sixteen ticks per bit; shifter advances once a bit
// (RULE_06) finished characters enter a two-entry buffer; third may be arriving
// (RULE_07) receiver works only with receive enable, async mode, port enable
// (RULE_08) tx pin is output only with port, async mode and transmit enabled; rx pin is always input
// (RULE_09) falling edge, wait half bit, resample; quietly abandon if not low
// (RULE_10) each later bit sampled at centre by majority, one bit apart
// (RULE_11) stop bit zero sets the character's frame error, one clears it
// (RULE_12) completed character enters buffer at once and data-available rises
// (RULE_13) reading receive data returns oldest low byte and removes it
// (RULE_14) data-available is read-only, high while unread data remains
// (RULE_15) rx interrupt only with rx, peripheral, global enables and flag
// (RULE_16) each entry keeps its frame error; status shows the entry last read out
// (RULE_17) frame error stops nothing, raises no interrupt, needs no clear
// (RULE_18) clearing port enable resets the transceiver and frame error
// (RULE_19) third character with buffer full sets overrun; reception halts
// (RULE_20) overrun clears when receive enable or port enable is cleared
// (RULE_21) nine-bit mode shifts nine bits; ninth shown as a status bit
// (RULE_22) software reads frame error and ninth bit after the data byte
// (RULE_23) characters travel lsb first, start bit low, stop bit high
// (RULE_24) sixteen-times tick comes from the shared baud divider
`timescale 1ns/1ps
module uart_rx_core
	import uart_rx_pkg::*;
#(
	parameter int DIV_WIDTH = 8
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	// serial pins
	input wire logic SERIAL_IN_PIN_I,
	output logic SERIAL_IN_PIN_OE,
	output logic SERIAL_OUT_PIN_OE,
	// interrupt request to cpu
	output logic IRQ
);
	import uart_rx_pkg::*;

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

	logic [CTRL_WIDTH-1:0] ctrl_reg;
	logic [DIV_WIDTH-1:0] baud_divisor_reg;
	logic [DIV_WIDTH-1:0] div_cnt_reg;
	logic tick;
	logic sync1_reg, sync2_reg, prev_reg;
	rx_state_e state_reg;
	logic [3:0] os_cnt_reg;
	logic [3:0] bit_cnt_reg;
	logic [2:0] votes_reg;
	logic [8:0] rx_shift_register_reg;
	logic overrun_flag_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic serial_port_enable, transmit_enable, receive_enable, rx_active;
	logic tx_buffer_empty_flag, rx_data_available_flag;
	logic fifo_push, fifo_pop, fifo_full, fifo_empty, xcvr_clear;
	logic [9:0] fifo_rdata;
	logic bus_req, bus_rd, bus_wr, frame_done;
	logic majority;
	logic frame_error_status_reg;
	logic rx_ninth_bit_reg;

	// ========================================
	// control decode
	assign serial_port_enable = ctrl_reg[CTRL_PORT_EN];
	assign transmit_enable = serial_port_enable && !ctrl_reg[CTRL_SYNC] && ctrl_reg[CTRL_TX_EN];
	assign receive_enable = ctrl_reg[CTRL_RX_EN];
	assign rx_active = receive_enable && !ctrl_reg[CTRL_SYNC] && serial_port_enable; // RULE_07
	assign xcvr_clear = RESET || !serial_port_enable; // RULE_18
	// no transmit shifter here, so the holding buffer is always empty once enabled
	assign tx_buffer_empty_flag = transmit_enable; // RULE_01
	assign rx_data_available_flag = !fifo_empty; // RULE_14
	assign SERIAL_OUT_PIN_OE = transmit_enable; // RULE_08
	assign SERIAL_IN_PIN_OE = 1'b0; // RULE_08
	// frame error deliberately absent from the interrupt term
	assign IRQ = ctrl_reg[CTRL_GIE] && ctrl_reg[CTRL_PERIPHERAL_INTERRUPT_ENABLE]
		&& ((ctrl_reg[CTRL_TX_INTERRUPT_ENABLE] && tx_buffer_empty_flag) // RULE_04
		|| (ctrl_reg[CTRL_RXIE] && rx_data_available_flag)); // RULE_15 RULE_17

	// ========================================
	// wishbone slave, one wait state, ack one cycle
	assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
	assign bus_wr = bus_req && WB_WE_I;
	assign bus_rd = bus_req && !WB_WE_I;
	assign WB_ACK_O = ack_reg;
	assign WB_ERR_O = 1'b0;
	assign WB_DAT_O = rdata_reg;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_req;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl_reg <= CTRL_RESET;
			baud_divisor_reg <= DIVISOR_RESET;
		end else if (bus_wr) begin
			if (WB_ADR_I == ADDR_CTRL) begin
				if (WB_SEL_I[0]) begin
					ctrl_reg[7:0] <= WB_DAT_I[7:0];
				end
				if (WB_SEL_I[1]) begin
					ctrl_reg[CTRL_WIDTH-1:8] <= WB_DAT_I[CTRL_WIDTH-1:8];
				end
			end else if (WB_ADR_I == ADDR_DIVISOR) begin
				if (WB_SEL_I[0]) begin
					baud_divisor_reg <= WB_DAT_I[DIV_WIDTH-1:0];
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rdata_reg <= 32'h0;
		end else if (bus_rd) begin
			rdata_reg <= 32'h0;
			if (WB_ADR_I == ADDR_CTRL) begin
				rdata_reg[CTRL_WIDTH-1:0] <= ctrl_reg;
			end else if (WB_ADR_I == ADDR_STATUS) begin
				rdata_reg[STAT_TXE] <= tx_buffer_empty_flag;
				rdata_reg[STAT_RXAV] <= rx_data_available_flag;
				rdata_reg[STAT_FRAME_ERROR_STATUS] <= frame_error_status_reg; // RULE_16
				rdata_reg[STAT_OVERRUN_FLAG] <= overrun_flag_reg;
				rdata_reg[STAT_RX_NINTH_BIT] <= rx_ninth_bit_reg; // RULE_21
				rdata_reg[STAT_IRQ] <= IRQ;
			end else if (WB_ADR_I == ADDR_RXDATA) begin
				rdata_reg[7:0] <= fifo_rdata[7:0]; // RULE_13
			end else if (WB_ADR_I == ADDR_DIVISOR) begin
				rdata_reg[DIV_WIDTH-1:0] <= baud_divisor_reg;
			end
		end
	end

	// a data read pops the oldest entry and keeps its flags for the status read after it
	assign fifo_pop = bus_rd && (WB_ADR_I == ADDR_RXDATA); // RULE_13

	// ========================================
	// flags of the character last taken from the buffer
	// held until the next data read, so status read after the byte shows that byte's flags
	always_ff @(posedge CLK) begin
		if (xcvr_clear) begin
			frame_error_status_reg <= 1'b0; // RULE_18
			rx_ninth_bit_reg <= 1'b0;
		end else if (fifo_pop && !fifo_empty) begin
			frame_error_status_reg <= fifo_rdata[9]; // RULE_16
			rx_ninth_bit_reg <= fifo_rdata[8]; // RULE_21
		end
	end

	// ========================================
	// shared baud divider, sixteen ticks per bit
	always_ff @(posedge CLK) begin
		if (xcvr_clear || div_cnt_reg == '0) begin
			div_cnt_reg <= baud_divisor_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg - 1'b1;
		end
	end
	assign tick = serial_port_enable && (div_cnt_reg == '0); // RULE_24 RULE_05

	// ========================================
	// pin synchroniser and receive recovery
	always_ff @(posedge CLK) begin
		if (RESET) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			sync1_reg <= SERIAL_IN_PIN_I;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign majority = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & votes_reg[2])
		| (votes_reg[1] & votes_reg[2]);

	always_ff @(posedge CLK) begin
		if (tick && os_cnt_reg == MID_A) begin
			votes_reg[0] <= sync2_reg;
		end
		if (tick && os_cnt_reg == MID_B) begin
			votes_reg[1] <= sync2_reg;
		end
		if (tick && os_cnt_reg == MID_C) begin
			votes_reg[2] <= sync2_reg;
		end
	end

	always_ff @(posedge CLK) begin
		if (xcvr_clear) begin
			state_reg <= RX_IDLE;
			os_cnt_reg <= 4'h0;
			bit_cnt_reg <= 4'h0;
			rx_shift_register_reg <= 9'h0;
		end else if (!rx_active || overrun_flag_reg) begin
			state_reg <= RX_IDLE; // RULE_19
		end else begin
			case (state_reg)
				RX_IDLE: begin
					if (prev_reg && !sync2_reg) begin
						state_reg <= RX_START;
						os_cnt_reg <= 4'h0;
					end
				end
				RX_START: begin
					if (tick) begin
						os_cnt_reg <= os_cnt_reg + 4'h1;
						// line high again at the start centre: noise, dropped without error
						if (os_cnt_reg == HALF_BIT && sync2_reg) begin // RULE_09
							state_reg <= RX_IDLE;
						end
						// run out the start bit so the counter wraps on every bit boundary
						if (os_cnt_reg == OVERSAMPLE_LAST) begin
							state_reg <= RX_DATA;
							bit_cnt_reg <= 4'h0;
						end
					end
				end
				RX_DATA: begin
					if (tick) begin
						os_cnt_reg <= os_cnt_reg + 4'h1;
						// votes fall around the centre, the shift at the bit's end, one bit apart
						if (os_cnt_reg == OVERSAMPLE_LAST) begin // RULE_10
							rx_shift_register_reg <= ctrl_reg[CTRL_RX9]
								? {majority, rx_shift_register_reg[8:1]}
								: {1'b0, majority, rx_shift_register_reg[7:1]}; // RULE_23
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == (ctrl_reg[CTRL_RX9] ? BITS_NINE : BITS_EIGHT)
								- 4'h1) begin // RULE_21
								state_reg <= RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					if (tick) begin
						os_cnt_reg <= os_cnt_reg + 4'h1;
						if (os_cnt_reg == OVERSAMPLE_LAST) begin
							state_reg <= RX_IDLE; // RULE_17
						end
					end
				end
				default: state_reg <= RX_IDLE;
			endcase
		end
	end

	assign frame_done = rx_active && !overrun_flag_reg && state_reg == RX_STOP && tick
		&& os_cnt_reg == OVERSAMPLE_LAST; // RULE_12
	assign fifo_push = frame_done && !fifo_full; // RULE_06

	// ========================================
	// overrun: set wins only while receive stays enabled
	always_ff @(posedge CLK) begin
		if (xcvr_clear || !receive_enable) begin
			overrun_flag_reg <= 1'b0; // RULE_20
		end else if (frame_done && fifo_full && !fifo_pop) begin
			overrun_flag_reg <= 1'b1; // RULE_19
		end
	end

	rx_fifo #(
		.WIDTH(10)
	) u_fifo (
		.clk(CLK),
		.clear(xcvr_clear), // RULE_18
		.push(fifo_push || (frame_done && fifo_pop)),
		.wdata({~majority, rx_shift_register_reg}), // RULE_11 RULE_16
		.pop(fifo_pop),
		.rdata(fifo_rdata),
		.empty(fifo_empty),
		.full(fifo_full)
	);
endmodule

// *** uart_rx_core_asserts.sv ***
// checker: bus handshake, pin direction and interrupt relations
`timescale 1ns/1ps
module uart_rx_core_asserts
	import uart_rx_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic WB_ERR_O,
	// pins
	input wire logic SERIAL_IN_PIN_OE,
	input wire logic SERIAL_OUT_PIN_OE,
	input wire logic IRQ
);
	// ==========
	// shadow of the control register
	logic [CTRL_WIDTH-1:0] ctrl_reg;
	logic tx_act;
	logic take;
	assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign tx_act = ctrl_reg[CTRL_PORT_EN] && !ctrl_reg[CTRL_SYNC] && ctrl_reg[CTRL_TX_EN];
	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl_reg <= CTRL_RESET;
		end else if (take && WB_WE_I && WB_ADR_I == ADDR_CTRL) begin
			if (WB_SEL_I[0]) ctrl_reg[7:0] <= WB_DAT_I[7:0];
			if (WB_SEL_I[1]) ctrl_reg[10:8] <= WB_DAT_I[10:8];
		end
	end
	// ==========
	// properties; ack cycles skipped where the write may still be landing
	sequence answer_s;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	a_ack_single_pulse:
		assert property (take |=> answer_s) else $error("ack not one pulse");
	a_ack_has_cause:
		assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
	a_err_stays_low:
		assert property (!WB_ERR_O) else $error("err raised");
	a_rx_pin_input:
		assert property (!SERIAL_IN_PIN_OE) else $error("rx pin driven");
	a_tx_pin_output:
		assert property (!WB_ACK_O |-> SERIAL_OUT_PIN_OE == tx_act) else $error("tx pin dir");
	a_tx_irq_now:
		assert property (!WB_ACK_O && tx_act && ctrl_reg[CTRL_TX_INTERRUPT_ENABLE] && ctrl_reg[CTRL_PERIPHERAL_INTERRUPT_ENABLE]
			&& ctrl_reg[CTRL_GIE] |-> IRQ) else $error("tx irq missing");
	a_irq_gated:
		assert property (!WB_ACK_O && IRQ |-> ctrl_reg[CTRL_GIE] && ctrl_reg[CTRL_PERIPHERAL_INTERRUPT_ENABLE]
			&& (ctrl_reg[CTRL_TX_INTERRUPT_ENABLE] && tx_act || ctrl_reg[CTRL_RXIE])) else $error("irq ungated");
	a_status_txe:
		assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == ADDR_STATUS
			|-> WB_DAT_O[STAT_TXE] == tx_act) else $error("tx empty flag");
	a_unmapped_zero:
		assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[1:0] != 2'h0 |-> WB_DAT_O == 32'h0)
			else $error("unmapped read");
endmodule
bind uart_rx_core uart_rx_core_asserts chk (.CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .SERIAL_IN_PIN_OE,
	.SERIAL_OUT_PIN_OE, .IRQ);

// *** uart_rx_pkg.sv ***
// package: register map, field positions and reset values for the serial transceiver
package uart_rx_pkg;
	// register byte addresses (word aligned)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_RXDATA = 4'h8;
	localparam logic [3:0] ADDR_DIVISOR = 4'hc;
	// control register fields
	localparam int CTRL_PORT_EN = 0;
	localparam int CTRL_SYNC = 1;
	localparam int CTRL_TX_EN = 2;
	localparam int CTRL_RX_EN = 3;
	localparam int CTRL_TX9 = 4;
	localparam int CTRL_RX9 = 5;
	localparam int CTRL_TX_NINTH_BIT = 6;
	localparam int CTRL_TX_INTERRUPT_ENABLE = 7;
	localparam int CTRL_RXIE = 8;
	localparam int CTRL_PERIPHERAL_INTERRUPT_ENABLE = 9;
	localparam int CTRL_GIE = 10;
	localparam int CTRL_WIDTH = 11;
	// status register fields
	localparam int STAT_TXE = 0;
	localparam int STAT_RXAV = 1;
	localparam int STAT_FRAME_ERROR_STATUS = 2;
	localparam int STAT_OVERRUN_FLAG = 3;
	localparam int STAT_RX_NINTH_BIT = 4;
	localparam int STAT_IRQ = 5;
	// reset values and counts
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 11'h000;
	localparam logic [7:0] DIVISOR_RESET = 8'h00;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] HALF_BIT = 4'h7;
	localparam logic [3:0] MID_A = 4'h6;
	localparam logic [3:0] MID_B = 4'h7;
	localparam logic [3:0] MID_C = 4'h8;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
endpackage
